// [cra_pkg.sv]
// Shared constants and types for the register access block.
// Assumes both ends are compiled after this package.
package cra_pkg;

	// ----------------------------------------------------------------
	// I/O map and pointer layout
	// ----------------------------------------------------------------
	localparam logic [15:0] IO_PTR_ADDR = 16'h0010;
	localparam logic [15:0] IO_DATA_ADDR = 16'h0014;
	localparam int PTR_EN_BIT = 31;
	localparam int PTR_IDX_LSB = 2;
	localparam int PTR_IDX_W = 6;
	localparam logic [31:0] PTR_RESET = 32'h00000000;

	// ----------------------------------------------------------------
	// Configuration dword indices and field positions
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_IDENT = 6'h00;
	localparam logic [5:0] IDX_CTRL = 6'h01;
	localparam logic [5:0] IDX_STAT = 6'h02;
	localparam logic [5:0] IDX_ONCE = 6'h03;
	localparam int LANE_W = 8;
	localparam int CTRL_RW_LSB = 0;
	localparam int CTRL_LK_LSB = 8;
	localparam int CTRL_LOCK_BIT = 7;
	localparam int STAT_ERR_LSB = 0;
	localparam int STAT_SET_LSB = 8;
	localparam int STAT_HW_LSB = 16;
	localparam int ONCE_LSB = 0;
	localparam int CMD_LSB = 8;
	// Arbitrary identification value
	localparam logic [31:0] IDENT_VALUE = 32'h0000C0DE;
	localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [31:0] RESV_NONE = 32'h00000000;
	localparam logic [31:0] RESV_STAT = 32'hFF000000;
	localparam logic [31:0] RESV_ONCE = 32'hFFFF0000;
	localparam logic [3:0] BE_NONE = 4'h0;
	localparam logic [3:0] BE_BYTE = 4'h1;
	localparam logic [3:0] BE_WORD = 4'h3;
	localparam logic [3:0] BE_DWORD = 4'hF;

	typedef enum logic [1:0] {
		CRA_SZ_BYTE = 2'h0,
		CRA_SZ_WORD = 2'h1,
		CRA_SZ_DWORD = 2'h2
	} cra_size_t;

	// Expands byte enables to a bit mask
	function automatic logic [31:0] cra_lane_mask(input logic [3:0] be);
		logic [31:0] m;
		m = ZERO_WORD;
		for (int i = 0; i < 4; i++)
			m[i*LANE_W +: LANE_W] = {LANE_W{be[i]}};
		return m;
	endfunction : cra_lane_mask

	// Reserved positions of each configuration dword
	function automatic logic [31:0] cra_resv_mask(input logic [5:0] idx);
		logic [31:0] m;
		m = RESV_NONE;
		if (idx == IDX_STAT)
			m = RESV_STAT;
		else if (idx == IDX_ONCE)
			m = RESV_ONCE;
		return m;
	endfunction : cra_resv_mask

endpackage : cra_pkg

// [cra_if.sv]
// Link between the host end and the register end.
// Assumes one clock; the host holds req until it sees ack.
`timescale 1ns/100ps
interface cra_if;
	logic req;
	logic we;
	logic [15:0] addr;
	logic [3:0] be;
	logic [31:0] wdata;
	logic ack;
	logic [31:0] rdata;

	modport dev (input req, we, addr, be, wdata, output ack, rdata);
	modport host (output req, we, addr, be, wdata, input ack, rdata);
endinterface : cra_if

// [cra_device.sv]
// Register end: I/O pointer plus data window onto a small config space.
// Assumes the host keeps req high until ack, and that hw_* inputs
// come from logic on clk.
`timescale 1ns/100ps
// Summary of operation
// - I/O pointer register steers config space access
// - Byte, word and dword accesses accepted
// - Pointer register written only by dword
// - Lowest byte address holds least significant
// - Read-only bits ignore writes
// - Write-only location fires hardware action
// - Read/write bits return stored value
// - Set-flag bits set by one, cleared by hardware
// - Lockable bits ignore writes while locked
// - Write-once bits lock after first write
// - Host masks reserved bits on reads
// - Host read-merge-writes registers with reserved bits
// - Pointer register written without read-merge-write
// - Sticky error bits survive hard reset
// - Hard reset spares sticky; power-good resets all
module cra_device
	import cra_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hard_reset_in_n,
	cra_if.dev bus,
	input wire logic hw_lock,
	input wire logic [7:0] hw_err_evt,
	input wire logic [7:0] hw_done,
	input wire logic [7:0] hw_status,
	output logic [7:0] ctrl_byte,
	output logic [7:0] lock_byte,
	output logic [7:0] err_flags,
	output logic [7:0] set_flags,
	output logic [7:0] once_byte,
	output logic [7:0] cmd_code,
	output logic cmd_strobe
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic hrst_n;
	logic ack_r, ack_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [31:0] ptr_r, ptr_nxt;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [7:0] lock_r, lock_nxt;
	logic [7:0] err_r, err_nxt;
	logic [7:0] set_r, set_nxt;
	logic [7:0] once_r, once_nxt;
	logic once_used_r, once_used_nxt;
	logic [7:0] cmd_r, cmd_nxt;
	logic strobe_r, strobe_nxt;

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	logic take, wr, rd;
	logic ptr_hit, data_hit;
	logic [5:0] idx;
	logic [31:0] wmask;
	logic [31:0] wd;
	logic [31:0] cfg_rd;
	logic locked;

	// Hard reset folds into the non-sticky domain only
	assign hrst_n = rst_n & hard_reset_in_n;

	// Second cycle of a held request is not taken again
	assign take = bus.req & ~ack_r;
	assign wr = take & bus.we;
	assign rd = take & ~bus.we;
	assign ptr_hit = (bus.addr == IO_PTR_ADDR);
	assign data_hit = (bus.addr == IO_DATA_ADDR) & ptr_r[PTR_EN_BIT];
	assign idx = ptr_r[PTR_IDX_LSB +: PTR_IDX_W];
	// Lane i carries byte address offset i
	assign wmask = cra_lane_mask(bus.be);
	assign wd = bus.wdata;
	assign locked = ctrl_r[CTRL_LOCK_BIT] | hw_lock;

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------
	always_comb
	begin
		cfg_rd = ALL_ONES;
		case (idx)
			IDX_IDENT: cfg_rd = IDENT_VALUE;
			IDX_CTRL: cfg_rd = {ZERO_BYTE, ZERO_BYTE, lock_r, ctrl_r};
			IDX_STAT: cfg_rd = {ZERO_BYTE, hw_status, set_r, err_r};
			// Command lane reads zero
			IDX_ONCE: cfg_rd = {ZERO_BYTE, ZERO_BYTE, ZERO_BYTE, once_r};
			default: cfg_rd = ALL_ONES;
		endcase
	end

	// ----------------------------------------------------------------
	// Next-state for the link and non-sticky registers
	// ----------------------------------------------------------------
	always_comb
	begin
		ack_nxt = take;
		rdata_nxt = rdata_r;
		ptr_nxt = ptr_r;
		ctrl_nxt = ctrl_r;
		lock_nxt = lock_r;
		set_nxt = set_r & ~hw_done;
		once_nxt = once_r;
		once_used_nxt = once_used_r;
		cmd_nxt = cmd_r;
		strobe_nxt = 1'b0;
		if (rd)
		begin
			// Unmapped or disabled window reads all ones
			if (ptr_hit)
				rdata_nxt = ptr_r;
			else if (data_hit)
				rdata_nxt = cfg_rd;
			else
				rdata_nxt = ALL_ONES;
		end
		if (wr && ptr_hit && bus.be == BE_DWORD)
			ptr_nxt = wd;
		if (wr && data_hit)
		begin
			case (idx)
				IDX_CTRL:
				begin
					if (bus.be[CTRL_RW_LSB / LANE_W])
						ctrl_nxt = wd[CTRL_RW_LSB +: LANE_W];
					if (bus.be[CTRL_LK_LSB / LANE_W] && !locked)
						lock_nxt = wd[CTRL_LK_LSB +: LANE_W];
				end
				IDX_STAT:
				begin
					// Software set wins over a same-cycle hardware clear
					set_nxt = set_nxt
						| (wd[STAT_SET_LSB +: LANE_W]
						& wmask[STAT_SET_LSB +: LANE_W]);
				end
				IDX_ONCE:
				begin
					if (bus.be[ONCE_LSB / LANE_W] && !once_used_r)
					begin
						once_nxt = wd[ONCE_LSB +: LANE_W];
						once_used_nxt = 1'b1;
					end
					if (bus.be[CMD_LSB / LANE_W])
					begin
						cmd_nxt = wd[CMD_LSB +: LANE_W];
						strobe_nxt = 1'b1;
					end
				end
				// Read-only identity and unmapped dwords drop writes
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sticky error flags
	// ----------------------------------------------------------------
	always_comb
	begin
		err_nxt = err_r;
		if (wr && data_hit && idx == IDX_STAT)
			err_nxt = err_r & ~(wd[STAT_ERR_LSB +: LANE_W]
				& wmask[STAT_ERR_LSB +: LANE_W]);
		// Event in the clearing cycle is kept
		err_nxt = err_nxt | hw_err_evt;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge hrst_n)
	begin
		if (!hrst_n)
		begin
			ack_r <= 1'b0;
			rdata_r <= ZERO_WORD;
			ptr_r <= PTR_RESET;
			ctrl_r <= ZERO_BYTE;
			lock_r <= ZERO_BYTE;
			set_r <= ZERO_BYTE;
			once_r <= ZERO_BYTE;
			once_used_r <= 1'b0;
			cmd_r <= ZERO_BYTE;
			strobe_r <= 1'b0;
		end
		else
		begin
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
			ptr_r <= ptr_nxt;
			ctrl_r <= ctrl_nxt;
			lock_r <= lock_nxt;
			set_r <= set_nxt;
			once_r <= once_nxt;
			once_used_r <= once_used_nxt;
			cmd_r <= cmd_nxt;
			strobe_r <= strobe_nxt;
		end
	end

	// Only the power-good reset clears these
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			err_r <= ZERO_BYTE;
		else
			err_r <= err_nxt;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus.ack = ack_r;
	assign bus.rdata = rdata_r;
	assign ctrl_byte = ctrl_r;
	assign lock_byte = lock_r;
	assign err_flags = err_r;
	assign set_flags = set_r;
	assign once_byte = once_r;
	assign cmd_code = cmd_r;
	assign cmd_strobe = strobe_r;

endmodule : cra_device

// [cra_host.sv]
// Host end: turns sized, right-aligned commands into lane accesses.
// Assumes the register end answers each taken request with one ack.
`timescale 1ns/100ps
module cra_host
	import cra_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	cra_if.host bus,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [15:0] cmd_addr,
	input wire cra_pkg::cra_size_t cmd_size,
	input wire logic [31:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [31:0] rsp_data,
	output logic rsp_err
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_RMW = 2'b01,
		H_XFER = 2'b11,
		H_RESP = 2'b10
	} cra_hstate_t;

	cra_hstate_t st_r, st_nxt;
	logic req_r, req_nxt, we_r, we_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic [3:0] be_r, be_nxt;
	logic [31:0] wd_r, wd_nxt, rsp_r, rsp_nxt, rmask_r, rmask_nxt;
	logic [31:0] resv_r, resv_nxt, shadow_r, shadow_nxt;
	logic err_r, err_nxt;
	logic [1:0] ofs_r, ofs_nxt;
	logic ready_r, ready_nxt, valid_r, valid_nxt;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	logic [1:0] ofs;
	logic [3:0] be_base, be_c;
	logic bad, win;
	logic [31:0] resv_c;

	assign ofs = cmd_addr[1:0];
	assign be_base = (cmd_size == CRA_SZ_DWORD) ? BE_DWORD :
		(cmd_size == CRA_SZ_WORD) ? BE_WORD : BE_BYTE;
	assign be_c = be_base << ofs;
	// Lane overflow or narrow pointer access is refused locally
	// Whole dword compared so byte offsets 1 to 3 still hit
	assign bad = ((be_base << ofs) >> ofs) != be_base
		|| (cmd_addr[15:2] == IO_PTR_ADDR[15:2]
		&& cmd_size != CRA_SZ_DWORD);
	assign win = (cmd_addr[15:2] == IO_DATA_ADDR[15:2]) & shadow_r[PTR_EN_BIT];
	assign resv_c = win ? cra_resv_mask(shadow_r[PTR_IDX_LSB +: PTR_IDX_W])
		: RESV_NONE;

	always_comb
	begin
		st_nxt = st_r;
		req_nxt = req_r;
		we_nxt = we_r;
		addr_nxt = addr_r;
		be_nxt = be_r;
		wd_nxt = wd_r;
		rsp_nxt = rsp_r;
		rmask_nxt = rmask_r;
		resv_nxt = resv_r;
		shadow_nxt = shadow_r;
		err_nxt = err_r;
		ofs_nxt = ofs_r;
		case (st_r)
			H_IDLE:
				if (cmd_valid)
				begin
					addr_nxt = {cmd_addr[15:2], 2'b00};
					be_nxt = be_c;
					wd_nxt = cmd_wdata << {ofs, 3'b000};
					rmask_nxt = cra_lane_mask(be_c) & ~resv_c;
					resv_nxt = resv_c;
					ofs_nxt = ofs;
					err_nxt = bad;
					if (bad)
						st_nxt = H_RESP;
					else if (cmd_write && resv_c != RESV_NONE)
					begin
						// Fetch reserved contents first
						req_nxt = 1'b1;
						we_nxt = 1'b0;
						st_nxt = H_RMW;
					end
					else
					begin
						if (cmd_write && cmd_addr == IO_PTR_ADDR)
							shadow_nxt = cmd_wdata;
						req_nxt = 1'b1;
						we_nxt = cmd_write;
						st_nxt = H_XFER;
					end
				end
			H_RMW:
				if (bus.ack)
				begin
					wd_nxt = (bus.rdata & resv_r) | (wd_r & ~resv_r);
					we_nxt = 1'b1;
					st_nxt = H_XFER;
				end
			H_XFER:
				if (bus.ack)
				begin
					req_nxt = 1'b0;
					rsp_nxt = we_r ? ZERO_WORD
						: (bus.rdata & rmask_r) >> {ofs_r, 3'b000};
					st_nxt = H_RESP;
				end
			H_RESP:
				st_nxt = H_IDLE;
			default:
				st_nxt = H_IDLE;
		endcase
		// Handshake outputs leave flops
		ready_nxt = (st_nxt == H_IDLE);
		valid_nxt = (st_nxt == H_RESP);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r <= H_IDLE;
			req_r <= 1'b0;
			we_r <= 1'b0;
			addr_r <= IO_PTR_ADDR;
			be_r <= BE_NONE;
			wd_r <= ZERO_WORD;
			rsp_r <= ZERO_WORD;
			rmask_r <= ZERO_WORD;
			resv_r <= RESV_NONE;
			shadow_r <= PTR_RESET;
			err_r <= 1'b0;
			ofs_r <= 2'b00;
			ready_r <= 1'b1;
			valid_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			req_r <= req_nxt;
			we_r <= we_nxt;
			addr_r <= addr_nxt;
			be_r <= be_nxt;
			wd_r <= wd_nxt;
			rsp_r <= rsp_nxt;
			rmask_r <= rmask_nxt;
			resv_r <= resv_nxt;
			shadow_r <= shadow_nxt;
			err_r <= err_nxt;
			ofs_r <= ofs_nxt;
			ready_r <= ready_nxt;
			valid_r <= valid_nxt;
		end
	end

	assign bus.req = req_r;
	assign bus.we = we_r;
	assign bus.addr = addr_r;
	assign bus.be = be_r;
	assign bus.wdata = wd_r;
	assign cmd_ready = ready_r;
	assign rsp_valid = valid_r;
	assign rsp_data = rsp_r;
	assign rsp_err = err_r;

endmodule : cra_host

// [cra_assertions.sv]
// Checker for the link between host end and register end.
// Assumes link signals and both resets are wired in by name.
`timescale 1ns/100ps
module cra_assertions
	import cra_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hard_reset_in_n,
	input wire logic req,
	input wire logic we,
	input wire logic [15:0] addr,
	input wire logic [3:0] be,
	input wire logic [31:0] wdata,
	input wire logic ack,
	input wire logic [31:0] rdata
);
	// ----
	// Link checks
	// ----
	// Hard reset may clear ack and rdata, so it disables too
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n || !hard_reset_in_n);
	logic take;
	assign take = req && !ack;
	a_ack_next_cycle:
		assert property (take |=> ack)
		else $error("request not answered next cycle");
	a_ack_one_pulse:
		assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	a_no_idle_ack:
		assert property (!req |=> !ack)
		else $error("ack without request");
	a_req_held:
		assert property (take |=> $stable({req, addr, we, be, wdata}))
		else $error("request changed before ack");
	a_ptr_whole:
		assert property (req && we && addr == IO_PTR_ADDR |-> be == BE_DWORD)
		else $error("narrow write to pointer");
	a_addr_dword:
		assert property (req |-> addr[1:0] == 2'h0)
		else $error("address not dword aligned");
	a_lanes_joined:
		assert property (req |-> be inside {4'h1, 4'h2, 4'h4, 4'h8,
			4'h3, 4'h6, 4'hC, 4'hF})
		else $error("byte lanes not a legal size");
	a_unmapped_ones:
		assert property (take && !we && addr != IO_PTR_ADDR &&
			addr != IO_DATA_ADDR |=> rdata == ALL_ONES)
		else $error("unmapped read not all ones");
	a_rdata_held:
		assert property (!(take && !we) |=> $stable(rdata))
		else $error("read data changed without a read");
endmodule : cra_assertions

// [tb_top.sv]
// Testbench: host end and register end joined by the link.
// Assumes cra_pkg, cra_if, both ends and the checker compile first.
`timescale 1ns/100ps
module tb_top;
	import cra_pkg::*;
	localparam cra_size_t SB = CRA_SZ_BYTE;
	localparam cra_size_t SW = CRA_SZ_WORD;
	localparam cra_size_t SD = CRA_SZ_DWORD;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hard_reset_in_n = 1'b1;
	logic hw_lock = 1'b0;
	logic [7:0] hw_err_evt = 8'h00;
	logic [7:0] hw_done = 8'h00;
	logic [7:0] hw_status = 8'hA5;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic [15:0] cmd_addr = 16'h0000;
	cra_size_t cmd_size = CRA_SZ_BYTE;
	logic [31:0] cmd_wdata = 32'h00000000;
	logic cmd_ready, rsp_valid, rsp_err, cmd_strobe, got_err;
	logic [31:0] rsp_data;
	logic [7:0] ctrl_byte, lock_byte, err_flags, set_flags;
	logic [7:0] once_byte, cmd_code;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_strobe = 0;
	int n_ack = 0;
	int nb;
	cra_if link ();
	cra_host cra_host_i (.clk(clk), .rst_n(rst_n), .bus(link),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_size(cmd_size), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err));
	cra_device cra_device_i (.clk(clk), .rst_n(rst_n),
		.hard_reset_in_n(hard_reset_in_n), .bus(link), .hw_lock(hw_lock),
		.hw_err_evt(hw_err_evt), .hw_done(hw_done), .hw_status(hw_status),
		.ctrl_byte(ctrl_byte), .lock_byte(lock_byte), .err_flags(err_flags),
		.set_flags(set_flags), .once_byte(once_byte), .cmd_code(cmd_code),
		.cmd_strobe(cmd_strobe));
	cra_assertions cra_assertions_i (.clk(clk), .rst_n(rst_n),
		.hard_reset_in_n(hard_reset_in_n), .req(link.req), .we(link.we),
		.addr(link.addr), .be(link.be), .wdata(link.wdata), .ack(link.ack),
		.rdata(link.rdata));

	always #25 clk = ~clk;

	// Cuts a hang short well past the longest expected run
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			err_total++;
			end_of_test();
		end
	end

	always @(posedge clk)
	begin
		if (cmd_strobe === 1'b1)
			n_strobe++;
		if (link.ack === 1'b1)
			n_ack++;
	end

	// ----
	// Tasks
	// ----
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic op(input logic w, input logic [15:0] a,
		input cra_size_t s, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		while (cmd_ready !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_addr = a;
		cmd_size = s;
		cmd_wdata = d;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
		got_err = rsp_err;
	endtask : op

	task automatic rdc(input logic [15:0] a, input cra_size_t s,
		input logic [31:0] exp);
		op(1'b0, a, s, ZERO_WORD);
		chk("read data", exp, rsp_data);
	endtask : rdc

	task automatic pt(input logic [5:0] idx);
		op(1'b1, IO_PTR_ADDR, SD, {1'b1, 23'h0, idx, 2'h0});
	endtask : pt

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	// ----
	// Tests
	// ----
	initial
	begin
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		pt(IDX_IDENT);
		rdc(IO_DATA_ADDR, SD, IDENT_VALUE);
		op(1'b1, IO_DATA_ADDR, SD, ALL_ONES);
		rdc(IO_DATA_ADDR, SD, IDENT_VALUE);
		rdc(16'h0015, SB, {24'h0, IDENT_VALUE[15:8]});
		rdc(16'h0016, SW, {16'h0, IDENT_VALUE[31:16]});
		op(1'b1, IO_PTR_ADDR, SB, 32'h00000004);
		chk("rsp_err", 32'h1, {31'h0, got_err});
		rdc(IO_PTR_ADDR, SD, 32'h80000000);
		rdc(16'h0020, SD, ALL_ONES);
		$display("test ident done");
		pt(IDX_CTRL);
		rdc(IO_DATA_ADDR, SD, ZERO_WORD);
		op(1'b1, IO_DATA_ADDR, SB, 32'h5A);
		op(1'b1, 16'h0015, SB, 32'h33);
		rdc(IO_DATA_ADDR, SW, 32'h335A);
		hw_lock = 1'b1;
		op(1'b1, 16'h0015, SB, 32'h77);
		hw_lock = 1'b0;
		op(1'b1, IO_DATA_ADDR, SB, 32'h80);
		chk("ctrl_byte", 32'h80, {24'h0, ctrl_byte});
		op(1'b1, 16'h0015, SB, 32'h11);
		chk("lock_byte", 32'h33, {24'h0, lock_byte});
		op(1'b1, IO_DATA_ADDR, SB, 32'h00);
		op(1'b1, 16'h0015, SB, 32'h11);
		chk("lock_byte", 32'h11, {24'h0, lock_byte});
		$display("test ctrl done");
		nb = n_ack;
		pt(IDX_STAT);
		chk("link acks", nb + 1, n_ack);
		hw_err_evt = 8'h0F;
		@(posedge clk);
		#1;
		hw_err_evt = 8'h00;
		nb = n_ack;
		op(1'b1, IO_DATA_ADDR, SB, 32'h05);
		chk("link acks", nb + 2, n_ack);
		op(1'b1, IO_DATA_ADDR, SB, 32'h00);
		op(1'b1, 16'h0015, SB, 32'h81);
		op(1'b1, 16'h0015, SB, 32'h00);
		hw_done = 8'h01;
		@(posedge clk);
		#1;
		hw_done = 8'h00;
		chk("set_flags", 32'h80, {24'h0, set_flags});
		op(1'b1, 16'h0016, SB, 32'h00);
		rdc(IO_DATA_ADDR, SD, 32'h00A5800A);
		rdc(16'h0017, SB, ZERO_WORD);
		hard_reset_in_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		hard_reset_in_n = 1'b1;
		chk("err_flags", 32'h0A, {24'h0, err_flags});
		chk("set_flags", 32'h00, {24'h0, set_flags});
		$display("test stat done");
		pt(IDX_ONCE);
		op(1'b1, IO_DATA_ADDR, SB, 32'h3C);
		op(1'b1, IO_DATA_ADDR, SB, 32'hC3);
		chk("once_byte", 32'h3C, {24'h0, once_byte});
		nb = n_strobe;
		op(1'b1, 16'h0015, SB, 32'h42);
		chk("cmd_code", 32'h42, {24'h0, cmd_code});
		chk("strobes", nb + 1, n_strobe);
		rdc(IO_DATA_ADDR, SW, 32'h003C);
		op(1'b1, IO_PTR_ADDR, SD, ZERO_WORD);
		rdc(IO_DATA_ADDR, SD, ALL_ONES);
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		chk("err_flags", 32'h00, {24'h0, err_flags});
		pt(IDX_ONCE);
		op(1'b1, IO_DATA_ADDR, SB, 32'h99);
		chk("once_byte", 32'h99, {24'h0, once_byte});
		$display("test once done");
		end_of_test();
	end
endmodule : tb_top
